/* verilog/pmm_pkg.sv */
// Purpose: shared constants and types of the power mode manager
// Assumes: APB register map, one word per register
// Notes:   Operation rules listed below
//
// Operation
// - After reset the block runs in normal mode, all clocks under register control; the code holds every clock but the two slow oscillators on.
// - Deep-sleep, power-down enable and mode select pick the mode; taken at wait-for-interrupt only.
// - WAIT_FOR_INTERRUPT with all selection bits zero enters idle, stopping only the core clock.
// - Power-down with select 0, 1, 2 enters normal, low-leak, fast-wake power-down.
// - Power-down with select 4, 5, 6 enters standby zero, standby one, deep.
// - Normal, low-leak, fast-wake power-down keep only slow oscillators and their peripherals.
// - Standby and deep power-down switch core power off; only slow oscillators run.
// - Standby zero keeps SRAM bank zero, 32 kilobytes, retained.
// - Any interrupt wakes idle; every wake-up returns the core to normal mode.
// - Power-down accepts wake-up from every listed peripheral event source.
// - Slow oscillators in power-down follow enables software set in normal mode, except the slow internal oscillator at deep entry without wake-up timer.
// - Timer clock runs in power-down only from an enabled slow oscillator; halts deep.
// - Watchdog clock runs only from enabled slow internal oscillator; halts deep.
// - Real-time clock runs in all power-down modes from enabled slow crystal.
// - Serial port clock runs only from enabled slow crystal; halts in deep power-down.
// - Standby SRAM retention follows the retention setting software chose; standby zero also keeps bank zero.
// - Deep power-down entry without wake-up timer switches the slow internal oscillator off.

package pmm_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] sys_ctl_off    = 8'h00;
	localparam logic [7:0] pwr_ctl_off    = 8'h04;
	localparam logic [7:0] pmu_ctl_off    = 8'h08;
	localparam logic [7:0] clk_src_off    = 8'h0C;
	localparam logic [7:0] pwr_status_off = 8'h10;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int deep_sleep_pos = 2;
	localparam int pd_en_pos      = 7;
	localparam int lxt_en_pos     = 1;
	localparam int low_speed_internal_osc_en_pos    = 3;
	localparam int mode_sel_lsb   = 0;
	localparam int wkt_en_pos     = 8;
	localparam int retain_lsb     = 16;
	localparam int tmr_src_lsb    = 0;
	localparam int wdt_src_pos    = 4;
	localparam int rtc_src_pos    = 5;
	localparam int uart_src_pos   = 6;
	localparam int mode_stat_lsb  = 0;
	localparam int wake_flag_pos  = 8;

	// ****************************************
	// Codes and reset values
	// ****************************************
	localparam logic [2:0] sel_npd  = 3'h0;
	localparam logic [2:0] sel_low_leak_power_down = 3'h1;
	localparam logic [2:0] sel_fast_wake_power_down = 3'h2;
	localparam logic [2:0] sel_standby_power_down_zero = 3'h4;
	localparam logic [2:0] sel_standby_power_down_one = 3'h5;
	localparam logic [2:0] sel_dpd  = 3'h6;
	localparam logic [1:0] src_lxt  = 2'h1;
	localparam logic [1:0] src_low_speed_internal_osc = 2'h2;
	localparam int         wake_sources = 11;
	localparam int         sram_banks   = 4;
	localparam logic [31:0] ctl_reset   = 32'h0000_0000;

	typedef enum logic [3:0] {
		mode_normal, mode_entering, mode_idle, mode_npd, mode_low_leak_power_down,
		mode_fast_wake_power_down, mode_standby_power_down_zero, mode_standby_power_down_one, mode_dpd
	} mode_type;

	typedef struct packed {
		logic cpu;
		logic hclk;
		logic high_speed_crystal;
		logic high_speed_internal_osc;
		logic pll;
		logic flash;
		logic others;
		logic low_speed_crystal;
		logic low_speed_internal_osc;
		logic timer;
		logic wdt;
		logic rtc;
		logic uart;
		logic core_pwr;
		logic ldo_low;
	} gates_type;

endpackage

/* verilog/gate_if.sv */
// Purpose: carries mode and settings to the gate decoder and back
// Assumes: one clock domain
// Notes:   purely combinational signals
`timescale 1ns/100ps
`default_nettype none
interface gate_if #(parameter int banks = 4);
	pmm_pkg::mode_type  mode;
	logic               lxt_on;
	logic               low_speed_internal_osc_on;
	logic [1:0]         tmr_src;
	logic               wdt_src;
	logic               rtc_src;
	logic               uart_src;
	logic [banks-1:0]   retain_sel;
	pmm_pkg::gates_type gates;
	logic [banks-1:0]   retain;
	modport ctrl (output mode, lxt_on, low_speed_internal_osc_on, tmr_src, wdt_src, rtc_src,
		uart_src, retain_sel, input gates, retain);
	modport dec (input mode, lxt_on, low_speed_internal_osc_on, tmr_src, wdt_src, rtc_src,
		uart_src, retain_sel, output gates, retain);
endinterface
`default_nettype wire

/* verilog/gate_decode.sv */
// Purpose: per-mode clock, power and retention gating table
// Assumes: mode comes from the controller's state register
// Notes:   combinational; the controller registers the result
`timescale 1ns/100ps
`default_nettype none
module gate_decode (
	gate_if.dec gi
);
	logic slow_any;
	logic tmr_ok;

	always_comb begin
		slow_any = gi.lxt_on | gi.low_speed_internal_osc_on;
		tmr_ok = (gi.tmr_src == pmm_pkg::src_lxt && gi.lxt_on) ||
			(gi.tmr_src == pmm_pkg::src_low_speed_internal_osc && gi.low_speed_internal_osc_on);
		gi.gates = '0;
		gi.retain = '0;
		gi.gates.low_speed_crystal = gi.lxt_on;
		gi.gates.low_speed_internal_osc = gi.low_speed_internal_osc_on;
		gi.gates.rtc = gi.rtc_src & gi.lxt_on;
		case (gi.mode)
			pmm_pkg::mode_normal, pmm_pkg::mode_entering, pmm_pkg::mode_idle: begin
				gi.gates = '1;
				gi.gates.ldo_low = 1'b0;
				gi.gates.low_speed_crystal = gi.lxt_on;
				gi.gates.low_speed_internal_osc = gi.low_speed_internal_osc_on;
				gi.gates.cpu = (gi.mode != pmm_pkg::mode_idle);
				gi.retain = '1;
			end
			pmm_pkg::mode_npd, pmm_pkg::mode_low_leak_power_down, pmm_pkg::mode_fast_wake_power_down,
			pmm_pkg::mode_standby_power_down_zero, pmm_pkg::mode_standby_power_down_one: begin
				// Fast clocks stay off; only slow-sourced peripherals run
				gi.gates.timer = tmr_ok & slow_any;
				gi.gates.wdt = gi.wdt_src & gi.low_speed_internal_osc_on;
				gi.gates.uart = gi.uart_src & gi.lxt_on;
				gi.gates.core_pwr = (gi.mode == pmm_pkg::mode_npd ||
					gi.mode == pmm_pkg::mode_low_leak_power_down ||
					gi.mode == pmm_pkg::mode_fast_wake_power_down);
				gi.gates.ldo_low = (gi.mode == pmm_pkg::mode_low_leak_power_down);
				if (gi.gates.core_pwr) begin
					gi.retain = '1;
				end else begin
					gi.retain = gi.retain_sel;
					if (gi.mode == pmm_pkg::mode_standby_power_down_zero) begin
						gi.retain[0] = 1'b1;
					end
				end
			end
			default: begin
				// Deep power-down: only the real-time clock and the enabled slow oscillators may run
				gi.gates.core_pwr = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

/* verilog/power_mode_manager.sv */
// Purpose: power mode manager with APB registers
// Assumes: core raises wfi_req for one cycle and core_sleeping once asleep
// Notes:   gating outputs follow the mode one cycle later
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module power_mode_manager #(
	parameter int banks = pmm_pkg::sram_banks,
	parameter int nsrc  = pmm_pkg::wake_sources
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic                  pready,
	output logic                  pslverr,
	output logic [31:0]           prdata,
	input  wire logic             wfi_req,
	input  wire logic             core_sleeping,
	input  wire logic             irq_pending,
	input  wire logic [nsrc-1:0]  wake_src,
	output logic                  core_wake,
	output logic                  cpu_clk_en,
	output logic                  hclk_en,
	output logic                  hxt_en,
	output logic                  high_speed_internal_osc_en,
	output logic                  pll_en,
	output logic                  flash_en,
	output logic                  others_clk_en,
	output logic                  lxt_en,
	output logic                  low_speed_internal_osc_en,
	output logic                  timer_clk_en,
	output logic                  wdt_clk_en,
	output logic                  rtc_clk_en,
	output logic                  uart_clk_en,
	output logic                  core_pwr_en,
	output logic                  ldo_low_en,
	output logic [banks-1:0]      sram_retain
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		pmm_pkg::mode_type  mode;
		pmm_pkg::mode_type  target;
		logic               deep_sleep;
		logic               pd_en;
		logic [2:0]         mode_sel;
		logic               lxt_on;
		logic               low_speed_internal_osc_on;
		logic               wkt_en;
		logic [banks-1:0]   retain_sel;
		logic [1:0]         tmr_src;
		logic               wdt_src;
		logic               rtc_src;
		logic               uart_src;
		logic               wake_flag;
		logic               pready;
		logic               pslverr;
		logic [31:0]        prdata;
		logic               core_wake;
		pmm_pkg::gates_type gates;
		logic [banks-1:0]   retain;
	} state_type;

	state_type s_reg;
	state_type s_next;
	logic      wr_en;
	logic      setup;

	gate_if #(.banks(banks)) gb ();

	gate_decode u_dec (
		.gi (gb.dec)
	);

	assign gb.mode       = s_reg.mode;
	assign gb.lxt_on     = s_reg.lxt_on;
	assign gb.low_speed_internal_osc_on    = s_reg.low_speed_internal_osc_on;
	assign gb.tmr_src    = s_reg.tmr_src;
	assign gb.wdt_src    = s_reg.wdt_src;
	assign gb.rtc_src    = s_reg.rtc_src;
	assign gb.uart_src   = s_reg.uart_src;
	assign gb.retain_sel = s_reg.retain_sel;

	// Writes land only in the access cycle, never in setup
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & s_reg.pready & pwrite;

	// ****************************************
	// Mode selection at WAIT_FOR_INTERRUPT
	// ****************************************
	function automatic pmm_pkg::mode_type pick_mode(input logic ds, input logic pd,
			input logic [2:0] sel);
		pmm_pkg::mode_type m;
		m = pmm_pkg::mode_idle;
		if (ds && pd) begin
			case (sel)
				pmm_pkg::sel_npd:  m = pmm_pkg::mode_npd;
				pmm_pkg::sel_low_leak_power_down: m = pmm_pkg::mode_low_leak_power_down;
				pmm_pkg::sel_fast_wake_power_down: m = pmm_pkg::mode_fast_wake_power_down;
				pmm_pkg::sel_standby_power_down_zero: m = pmm_pkg::mode_standby_power_down_zero;
				pmm_pkg::sel_standby_power_down_one: m = pmm_pkg::mode_standby_power_down_one;
				pmm_pkg::sel_dpd:  m = pmm_pkg::mode_dpd;
				// Reserved codes fall back to the safest power-down
				default:           m = pmm_pkg::mode_npd;
			endcase
		end
		return m;
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_next = s_reg;
		s_next.core_wake = 1'b0;
		s_next.pready = setup;
		s_next.pslverr = 1'b0;
		s_next.gates = gb.gates;
		s_next.retain = gb.retain;

		// Read data is fetched in the setup phase, one wait-free access
		if (setup) begin
			s_next.prdata = 32'h0000_0000;
			case (paddr)
				pmm_pkg::sys_ctl_off:
					s_next.prdata[pmm_pkg::deep_sleep_pos] = s_reg.deep_sleep;
				pmm_pkg::pwr_ctl_off: begin
					s_next.prdata[pmm_pkg::pd_en_pos] = s_reg.pd_en;
					s_next.prdata[pmm_pkg::lxt_en_pos] = s_reg.lxt_on;
					s_next.prdata[pmm_pkg::low_speed_internal_osc_en_pos] = s_reg.low_speed_internal_osc_on;
				end
				pmm_pkg::pmu_ctl_off: begin
					s_next.prdata[pmm_pkg::mode_sel_lsb +: 3] = s_reg.mode_sel;
					s_next.prdata[pmm_pkg::wkt_en_pos] = s_reg.wkt_en;
					s_next.prdata[pmm_pkg::retain_lsb +: banks] = s_reg.retain_sel;
				end
				pmm_pkg::clk_src_off: begin
					s_next.prdata[pmm_pkg::tmr_src_lsb +: 2] = s_reg.tmr_src;
					s_next.prdata[pmm_pkg::wdt_src_pos] = s_reg.wdt_src;
					s_next.prdata[pmm_pkg::rtc_src_pos] = s_reg.rtc_src;
					s_next.prdata[pmm_pkg::uart_src_pos] = s_reg.uart_src;
				end
				pmm_pkg::pwr_status_off: begin
					s_next.prdata[pmm_pkg::mode_stat_lsb +: 4] = s_reg.mode;
					s_next.prdata[pmm_pkg::wake_flag_pos] = s_reg.wake_flag;
				end
				default: s_next.pslverr = 1'b1;
			endcase
		end else if (penable) begin
			s_next.pslverr = s_reg.pslverr;
		end

		if (wr_en) begin
			case (paddr)
				pmm_pkg::sys_ctl_off:
					s_next.deep_sleep = pwdata[pmm_pkg::deep_sleep_pos];
				pmm_pkg::pwr_ctl_off: begin
					s_next.pd_en = pwdata[pmm_pkg::pd_en_pos];
					s_next.lxt_on = pwdata[pmm_pkg::lxt_en_pos];
					s_next.low_speed_internal_osc_on = pwdata[pmm_pkg::low_speed_internal_osc_en_pos];
				end
				pmm_pkg::pmu_ctl_off: begin
					s_next.mode_sel = pwdata[pmm_pkg::mode_sel_lsb +: 3];
					s_next.wkt_en = pwdata[pmm_pkg::wkt_en_pos];
					s_next.retain_sel = pwdata[pmm_pkg::retain_lsb +: banks];
				end
				pmm_pkg::clk_src_off: begin
					s_next.tmr_src = pwdata[pmm_pkg::tmr_src_lsb +: 2];
					s_next.wdt_src = pwdata[pmm_pkg::wdt_src_pos];
					s_next.rtc_src = pwdata[pmm_pkg::rtc_src_pos];
					s_next.uart_src = pwdata[pmm_pkg::uart_src_pos];
				end
				pmm_pkg::pwr_status_off:
					if (pwdata[pmm_pkg::wake_flag_pos]) begin
						s_next.wake_flag = 1'b0;
					end
				default: ;
			endcase
		end

		// Mode sequencing; a wake-up set below wins over a clear above
		case (s_reg.mode)
			pmm_pkg::mode_normal: begin
				if (wfi_req) begin
					s_next.target = pick_mode(s_reg.deep_sleep, s_reg.pd_en,
						s_reg.mode_sel);
					s_next.mode = pmm_pkg::mode_entering;
				end
			end
			pmm_pkg::mode_entering: begin
				// Pending wake aborts entry; gating is still untouched
				if (irq_pending || (|wake_src)) begin
					s_next.mode = pmm_pkg::mode_normal;
					s_next.core_wake = 1'b1;
				end else if (core_sleeping) begin
					s_next.mode = s_reg.target;
					if (s_reg.target == pmm_pkg::mode_dpd && !s_reg.wkt_en) begin
						s_next.low_speed_internal_osc_on = 1'b0;
					end
				end
			end
			pmm_pkg::mode_idle: begin
				// Idle ignores peripheral events that raise no interrupt
				if (irq_pending) begin
					s_next.mode = pmm_pkg::mode_normal;
					s_next.core_wake = 1'b1;
					s_next.wake_flag = 1'b1;
				end
			end
			pmm_pkg::mode_npd, pmm_pkg::mode_low_leak_power_down, pmm_pkg::mode_fast_wake_power_down,
			pmm_pkg::mode_standby_power_down_zero, pmm_pkg::mode_standby_power_down_one, pmm_pkg::mode_dpd: begin
				if (|wake_src) begin
					s_next.mode = pmm_pkg::mode_normal;
					s_next.core_wake = 1'b1;
					s_next.wake_flag = 1'b1;
				end
			end
			default: s_next.mode = pmm_pkg::mode_normal;
		endcase
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.mode <= pmm_pkg::mode_normal;
			s_reg.target <= pmm_pkg::mode_normal;
			s_reg.gates <= '1;
			s_reg.gates.ldo_low <= 1'b0;
			s_reg.gates.low_speed_crystal <= pmm_pkg::ctl_reset[pmm_pkg::lxt_en_pos];
			s_reg.gates.low_speed_internal_osc <= pmm_pkg::ctl_reset[pmm_pkg::low_speed_internal_osc_en_pos];
			s_reg.retain <= '1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pready        = s_reg.pready;
	assign pslverr       = s_reg.pslverr;
	assign prdata        = s_reg.prdata;
	assign core_wake     = s_reg.core_wake;
	assign cpu_clk_en    = s_reg.gates.cpu;
	assign hclk_en       = s_reg.gates.hclk;
	assign hxt_en        = s_reg.gates.high_speed_crystal;
	assign high_speed_internal_osc_en       = s_reg.gates.high_speed_internal_osc;
	assign pll_en        = s_reg.gates.pll;
	assign flash_en      = s_reg.gates.flash;
	assign others_clk_en = s_reg.gates.others;
	assign lxt_en        = s_reg.gates.low_speed_crystal;
	assign low_speed_internal_osc_en       = s_reg.gates.low_speed_internal_osc;
	assign timer_clk_en  = s_reg.gates.timer;
	assign wdt_clk_en    = s_reg.gates.wdt;
	assign rtc_clk_en    = s_reg.gates.rtc;
	assign uart_clk_en   = s_reg.gates.uart;
	assign core_pwr_en   = s_reg.gates.core_pwr;
	assign ldo_low_en    = s_reg.gates.ldo_low;
	assign sram_retain   = s_reg.retain;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Gates are registered, so gate checks look one cycle after the mode

	// Shorthand for every power-down mode
	logic in_pd;
	assign in_pd = s_reg.mode inside {pmm_pkg::mode_npd, pmm_pkg::mode_low_leak_power_down,
		pmm_pkg::mode_fast_wake_power_down, pmm_pkg::mode_standby_power_down_zero, pmm_pkg::mode_standby_power_down_one, pmm_pkg::mode_dpd};

	a_normal_clocks: assert property (
		s_reg.mode == pmm_pkg::mode_normal |=> cpu_clk_en && hclk_en && core_pwr_en)
		else $error("normal mode lost a clock");
	a_sleep_sample: assert property (
		s_reg.mode == pmm_pkg::mode_normal && wfi_req |=> s_reg.mode == pmm_pkg::mode_entering
		&& s_reg.target == pick_mode($past(s_reg.deep_sleep), $past(s_reg.pd_en),
		$past(s_reg.mode_sel)))
		else $error("sleep request did not sample selection");
	a_idle_core_stop: assert property (
		s_reg.mode == pmm_pkg::mode_idle |=> !cpu_clk_en && hclk_en && pll_en)
		else $error("idle gating wrong");
	a_entry_target: assert property (
		s_reg.mode == pmm_pkg::mode_entering && core_sleeping && !irq_pending && !(|wake_src)
		|=> s_reg.mode == $past(s_reg.target))
		else $error("sleep entry took wrong mode");
	a_gate_hold: assert property (
		s_reg.mode == pmm_pkg::mode_entering && !core_sleeping
		|=> s_reg.mode inside {pmm_pkg::mode_entering, pmm_pkg::mode_normal} && cpu_clk_en && hclk_en)
		else $error("gating changed before core slept");
	a_pd_fast_off: assert property (
		in_pd |=> !hxt_en && !high_speed_internal_osc_en && !pll_en && !flash_en && !hclk_en && !others_clk_en)
		else $error("fast clock running in power-down");
	a_standby_off: assert property (
		s_reg.mode inside {pmm_pkg::mode_standby_power_down_zero, pmm_pkg::mode_standby_power_down_one, pmm_pkg::mode_dpd}
		|=> !core_pwr_en)
		else $error("core powered in standby");
	a_bank0_keep: assert property (
		s_reg.mode == pmm_pkg::mode_standby_power_down_zero |=> sram_retain[0])
		else $error("bank zero not retained");
	a_idle_wake: assert property (
		s_reg.mode == pmm_pkg::mode_idle && irq_pending
		|=> s_reg.mode == pmm_pkg::mode_normal && core_wake ##1 !core_wake)
		else $error("idle wake failed");
	a_pd_wake: assert property (
		in_pd && (|wake_src) |=> s_reg.mode == pmm_pkg::mode_normal && core_wake)
		else $error("power-down wake failed");
	a_slow_follow: assert property (
		in_pd |=> lxt_en == $past(s_reg.lxt_on) && low_speed_internal_osc_en == $past(s_reg.low_speed_internal_osc_on))
		else $error("slow oscillator enable wrong");
	a_deep_halt: assert property (
		s_reg.mode == pmm_pkg::mode_dpd |=> !timer_clk_en && !wdt_clk_en && !uart_clk_en)
		else $error("peripheral clock running in deep power-down");
	a_rtc_keep: assert property (
		in_pd |=> rtc_clk_en == $past(s_reg.rtc_src && s_reg.lxt_on))
		else $error("rtc clock gating wrong");
	a_retain_sel: assert property (
		s_reg.mode == pmm_pkg::mode_standby_power_down_one |=> sram_retain == $past(s_reg.retain_sel))
		else $error("standby retention ignores setting");
	a_slow_osc_auto: assert property (
		s_reg.mode == pmm_pkg::mode_entering && core_sleeping && !irq_pending && !(|wake_src)
		&& s_reg.target == pmm_pkg::mode_dpd && !s_reg.wkt_en |=> !s_reg.low_speed_internal_osc_on ##1 !low_speed_internal_osc_en)
		else $error("slow internal oscillator left on");
	a_wake_flag_set: assert property (
		in_pd && (|wake_src) |=> s_reg.wake_flag)
		else $error("wake flag not set on wake-up");
	a_bus_answer: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("register bus answer not one cycle");

	// Main scenarios: idle, deep and standby trips, aborted entry
	c_idle_trip: cover property (s_reg.mode == pmm_pkg::mode_idle ##[1:20] core_wake);
	c_standby_power_down_zero_trip: cover property (s_reg.mode == pmm_pkg::mode_standby_power_down_zero ##[1:20] core_wake);
	c_slow_osc_off: cover property (s_reg.mode == pmm_pkg::mode_dpd && !s_reg.low_speed_internal_osc_on);
	c_dpd_trip: cover property (s_reg.mode == pmm_pkg::mode_dpd ##[1:20] core_wake);
	c_abort: cover property (s_reg.mode == pmm_pkg::mode_entering && irq_pending);

endmodule
`default_nettype wire

/* test/core_model.sv */
// Purpose: behavioural core that issues the sleep request and reports sleep
// Assumes: one wfi_req pulse per sleep_cmd, sleep reported lag plus one cycles after wfi_req
// Notes:   a wake before sleep is reached cancels the pending sleep
`timescale 1ns/100ps
`default_nettype none
module core_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       sleep_cmd,
	input  wire logic [3:0] lag,
	input  wire logic       core_wake,
	output logic            wfi_req,
	output logic            core_sleeping
);
	typedef struct packed {
		logic       wait_for_interrupt;
		logic       slp;
		logic       pend;
		logic [3:0] cnt;
	} core_state_type;
	core_state_type state_reg;
	core_state_type state_next;
	always_comb begin
		state_next = state_reg;
		state_next.wait_for_interrupt = sleep_cmd;
		if (sleep_cmd) begin
			state_next.pend = 1'b1;
			state_next.cnt = lag;
		end else if (state_reg.pend) begin
			if (core_wake) begin
				state_next.pend = 1'b0;
			end else if (state_reg.cnt == 4'h0) begin
				state_next.slp = 1'b1;
				state_next.pend = 1'b0;
			end else begin
				state_next.cnt = state_reg.cnt - 4'h1;
			end
		end
		if (core_wake) begin
			state_next.slp = 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	assign wfi_req = state_reg.wait_for_interrupt;
	assign core_sleeping = state_reg.slp;
endmodule
`default_nettype wire

/* test/power_mode_manager_tb_top.sv */
// Purpose: self-checking bench of the power mode manager
// Assumes: zero wait state APB, gates follow mode one cycle later
// Notes:   core_model stands in for the processor core
`timescale 1ns/100ps
`default_nettype none
module power_mode_manager_tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        pready, pslverr, core_wake, wfi_req, core_sleeping, ldo_low_en;
	logic [31:0] prdata, rv;
	logic        ev;
	logic        irq_pending = 1'b0;
	logic        sleep_cmd = 1'b0;
	logic [3:0]  lag = 4'h0;
	logic [10:0] wake_src = 11'h000;
	logic [17:0] seen;
	int          miscompares = 0;
	int          checks_done = 0;
	int          low_speed_crystal, low_speed_internal_osc, tsrc, wsrc, rsrc, usrc, wkt, ret;

	// ****************************************
	// Clock, design and core
	// ****************************************
	always #10 pclk = ~pclk;

	power_mode_manager power_mode_manager_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.wfi_req(wfi_req), .core_sleeping(core_sleeping), .irq_pending(irq_pending), .wake_src(wake_src),
		.core_wake(core_wake), .cpu_clk_en(seen[17]), .hclk_en(seen[16]), .hxt_en(seen[15]),
		.high_speed_internal_osc_en(seen[14]), .pll_en(seen[13]), .flash_en(seen[12]), .others_clk_en(seen[11]),
		.lxt_en(seen[10]), .low_speed_internal_osc_en(seen[9]), .timer_clk_en(seen[8]), .wdt_clk_en(seen[7]),
		.rtc_clk_en(seen[6]), .uart_clk_en(seen[5]), .core_pwr_en(seen[4]), .ldo_low_en(ldo_low_en),
		.sram_retain(seen[3:0]));

	core_model core_model_i (.pclk(pclk), .presetn(presetn), .sleep_cmd(sleep_cmd), .lag(lag),
		.core_wake(core_wake), .wfi_req(wfi_req), .core_sleeping(core_sleeping));

	// ****************************************
	// Reference model
	// ****************************************
	function automatic int tgt(int ds, int pd, int sel);
		if (!(ds && pd)) return 2;
		case (sel)
			1: return 4;
			2: return 5;
			4: return 6;
			5: return 7;
			6: return 8;
			default: return 3;
		endcase
	endfunction

	function automatic logic [17:0] exp_g(int m);
		int deep, sb, li, tm;
		deep = (m == 8);
		sb = (m == 6 || m == 7);
		li = low_speed_internal_osc && !(deep && !wkt);
		tm = (tsrc == 1 && low_speed_crystal) || (tsrc == 2 && li);
		if (m < 3) return {m != 2, 6'h3f, low_speed_crystal[0], li[0], 5'h1f, 4'hf};
		return {7'h00, low_speed_crystal[0], li[0], tm && !deep, wsrc && li && !deep, rsrc && low_speed_crystal,
			usrc && low_speed_crystal && !deep, !(sb || deep),
			sb ? ((m == 6) ? (ret[3:0] | 4'h1) : ret[3:0]) : (deep ? 4'h0 : 4'hf)};
	endfunction

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1 && n < 20) begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk(s, 1);
	endtask

	task automatic sleep(int ds, int pd, int sel, int abort);
		int m;
		m = abort ? 0 : tgt(ds, pd, sel);
		low_speed_crystal = $urandom % 2;
		low_speed_internal_osc = ($urandom % 2) | (sel == 4 || sel == 5);
		{tsrc, wsrc, rsrc, usrc, wkt, ret} = {$urandom % 4, $urandom % 2, $urandom % 2, $urandom % 2,
			$urandom % 2, $urandom % 16};
		apb(1, pmm_pkg::sys_ctl_off, ds << 2);
		apb(1, pmm_pkg::pwr_ctl_off, (pd << 7) | (low_speed_internal_osc << 3) | (low_speed_crystal << 1));
		apb(1, pmm_pkg::pmu_ctl_off, sel | (wkt << 8) | (ret << 16));
		apb(1, pmm_pkg::clk_src_off, tsrc | (wsrc << 4) | (rsrc << 5) | (usrc << 6));
		@(posedge pclk);
		sleep_cmd <= 1'b1;
		lag <= abort ? 4'h8 : 4'($urandom % 4);
		@(posedge pclk);
		sleep_cmd <= 1'b0;
		if (!abort) begin
			wait_hi(core_sleeping);
			repeat (3) @(posedge pclk);
			#1 chk(seen, exp_g(m));
			chk(ldo_low_en, m == 4);
			apb(0, pmm_pkg::pwr_status_off, 0);
			chk(rv[3:0], m);
		end
		@(posedge pclk);
		if (m == 2 || abort) irq_pending <= 1'b1;
		else wake_src <= 11'h001 << ($urandom % 11);
		wait_hi(core_wake);
		@(posedge pclk);
		irq_pending <= 1'b0;
		wake_src <= 11'h000;
		if (m == 8 && !wkt) low_speed_internal_osc = 0;
		repeat (2) @(posedge pclk);
		#1 chk(seen, exp_g(0));
		chk(core_sleeping, 0);
		chk(ldo_low_en, 0);
		apb(0, pmm_pkg::pwr_status_off, 0);
		chk(rv, abort ? 32'h0000_0000 : 32'h0000_0100);
		apb(1, pmm_pkg::pwr_status_off, 32'h0000_0100);
		apb(0, pmm_pkg::pwr_status_off, 0);
		chk(rv, 0);
	endtask

	task automatic stop_test;
		if (miscompares == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ****************************************
	// Sequence and watchdog
	// ****************************************
	initial begin
		#200_000;
		miscompares++;
		stop_test();
	end

	initial begin
		void'($urandom(52));
		low_speed_crystal = 0;
		low_speed_internal_osc = 0;
		{tsrc, wsrc, rsrc, usrc, wkt, ret} = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1 chk(seen, exp_g(0));
		for (int a = 0; a <= 32; a += 4) begin
			apb(0, 8'(a), 0);
			chk(rv, 0);
			chk(ev, a > 16);
		end
		sleep(0, 0, 0, 0);
		sleep(1, 0, 4, 0);
		for (int s = 0; s < 8; s++) sleep(1, 1, s, 0);
		sleep(1, 1, 6, 0);
		sleep(1, 1, 0, 1);
		stop_test();
	end
endmodule
`default_nettype wire
